// file: hw/vpic_pkg.sv
/*
 * Constants for the vectored priority interrupt controller: register
 * word indices, field positions, reset values and vector table bases.
 * Assumes a 16-bit register port addressed by word index.
 */
package vpic_pkg;
    // Source counts
    localparam int N_SRC = 72;
    localparam int N_FLAG_REGS = 5;
    localparam int N_PRIO_REGS = 18;
    localparam int N_EXT = 5;
    localparam int N_EVT = 3;
    localparam int PRIO_SLOT = 4;

    // Register word indices
    localparam logic [5:0] ADDR_CTRL_ONE = 6'h00;
    localparam logic [5:0] ADDR_CTRL_TWO = 6'h01;
    localparam logic [5:0] ADDR_FLAG_BASE = 6'h02;
    localparam logic [5:0] ADDR_EN_BASE = 6'h07;
    localparam logic [5:0] ADDR_PRIO_BASE = 6'h0c;
    localparam logic [5:0] ADDR_STATUS_WORD = 6'h1e;
    localparam logic [5:0] ADDR_CORE_CTRL = 6'h1f;
    localparam logic [5:0] ADDR_EVT_STAT = 6'h20;
    localparam logic [5:0] ADDR_EVT_MASK = 6'h21;

    // Field positions
    localparam int NEST_OFF_BIT = 15;
    localparam int ALT_TABLE_BIT = 15;
    localparam int IPL_LSB = 5;
    localparam int CPU_PRIO_HIGH_BIT_BIT = 3;
    localparam logic [15:0] CTRL_ONE_WMASK = 16'hfffe;
    localparam logic [15:0] CTRL_TWO_WMASK = 16'h801f;
    localparam logic [15:0] PRIO_WMASK = 16'h7777;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [2:0] IPL_RST = 3'h0;

    // Event bits
    localparam int EVT_PEND = 0;
    localparam int EVT_EXT = 1;
    localparam int EVT_TRAP = 2;

    // Vectoring
    localparam logic [7:0] VEC_OFFSET = 8'h08;
    localparam logic [23:0] IVT_BASE = 24'h000004;
    localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE = 24'h000104;

    // Request numbers of the external inputs 0..4
    localparam int EXT_IRQ [N_EXT] = '{0, 20, 29, 53, 54};
endpackage

// file: hw/vpic_arbiter.sv
/*
 * Combinational priority pick among pending enabled sources.
 * Assumes pend already holds flag AND enable.
 */
`timescale 1ns/10ps
`default_nettype none
module vpic_arbiter #(
    parameter int N_SRC = 72
) (
    // Requests
    input wire logic [N_SRC-1:0] pend,
    input wire logic [3*N_SRC-1:0] prio_flat,
    input wire logic [3:0] level,
    // Winner
    output logic valid,
    output logic [6:0] id,
    output logic [2:0] prio
);
    logic blocked;

    // High level bit or level 7 shuts out every user source
    assign blocked = level[3] || (level[2:0] == 3'h7);

    // Strict compare keeps the lowest number on a tie
    always_comb begin
        logic [2:0] floor_prio;
        floor_prio = level[2:0];
        valid = 1'b0;
        id = 7'h00;
        prio = 3'h0;
        for (int i = 0; i < N_SRC; i++) begin
            if (pend[i] && prio_flat[3*i +: 3] > floor_prio) begin
                valid = 1'b1;
                id = 7'(i);
                prio = prio_flat[3*i +: 3];
                floor_prio = prio_flat[3*i +: 3];
            end
        end
        if (blocked) begin
            valid = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hw/vpic_ctrl.sv
/*
 * Vectored priority interrupt controller: flags, enables, priorities,
 * CPU priority level, vector selection and an event interrupt.
 * Assumes a synchronous register port with read data one cycle later
 * and a core that acknowledges a presented request with irq_ack.
 */
//
// Contract
// - Thirty registers: two global, five flag, five enable, eighteen priority.
// - First global register holds nesting-off and trap control and flags.
// - Second global register holds external edge polarity and table select.
// - Each source flag is set by hardware, stays set until software clears.
// - A source is acted on only while its enable bit is set.
// - Each user source has a three-bit priority, eight levels.
// - Bits go to sources in request order, request 0 at bit 0.
// - Request n uses vector n+8; vector 63 entry at 0x000082.
// - Status word bits 7:5 hold low level bits, software writable.
// - High level bit sits in core control word, read-only to software.
// - Effective level is high bit above the three low bits.
// - Low level bits equal seven block all user interrupts.
// - High level bit set blocks all user interrupts.
// - Low level bits read-only while nesting-off is set.
// - Nesting-off is bit 15 of first global register, resets to 0.
// - Table select one picks alternate table, zero standard, resets 0.
// - Edge polarity one means falling edge, zero rising edge.
`timescale 1ns/10ps
`default_nettype none
module vpic_ctrl #(
    parameter int N_SRC = vpic_pkg::N_SRC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Request sources
    input wire logic [N_SRC-1:0] periph_req,
    input wire logic [vpic_pkg::N_EXT-1:0] ext_req,
    input wire logic [15:0] trap_flag_set,
    input wire logic trap_enter,
    input wire logic trap_exit,
    // Core side
    output logic irq_req,
    output logic [7:0] irq_vec_num,
    output logic [23:0] irq_vec_addr,
    output logic [2:0] irq_prio,
    input wire logic irq_ack,
    output logic [3:0] cpu_prio_level,
    // Event interrupt
    output logic irq_out
);
    localparam int FLAG_W = 16 * vpic_pkg::N_FLAG_REGS;

    function automatic logic in_range(input logic [5:0] a,
                                      input logic [5:0] base, input int n);
        return (a >= base) && (a < base + 6'(n));
    endfunction

    function automatic logic [23:0] vec_addr(input logic alt,
                                             input logic [7:0] vec);
        return (alt ? vpic_pkg::ALTERNATE_VECTOR_TABLE_BASE : vpic_pkg::IVT_BASE)
            + {15'h0000, vec, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [15:0] irq_global_ctrl_one;
    logic [15:0] irq_global_ctrl_two;
    logic [FLAG_W-1:0] flag_bits;
    logic [FLAG_W-1:0] enable_bits;
    logic [15:0] prio_reg [vpic_pkg::N_PRIO_REGS];
    logic [2:0] cpu_prio_low_bits;
    logic cpu_prio_high_bit;
    logic [vpic_pkg::N_EXT-1:0] ext_prev;
    logic [vpic_pkg::N_EVT-1:0] evt_stat;
    logic [vpic_pkg::N_EVT-1:0] evt_mask;
    logic [6:0] irq_id;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire logic nesting_off = irq_global_ctrl_one[vpic_pkg::NEST_OFF_BIT];
    wire logic alt_table_select = irq_global_ctrl_two[vpic_pkg::ALT_TABLE_BIT];
    wire logic [vpic_pkg::N_EXT-1:0] ext_edge_polarity =
        irq_global_ctrl_two[vpic_pkg::N_EXT-1:0];
    wire logic wr_one = reg_wr && reg_addr == vpic_pkg::ADDR_CTRL_ONE;
    wire logic wr_two = reg_wr && reg_addr == vpic_pkg::ADDR_CTRL_TWO;
    wire logic wr_flag = reg_wr && in_range(reg_addr, vpic_pkg::ADDR_FLAG_BASE,
                                            vpic_pkg::N_FLAG_REGS);
    wire logic wr_en = reg_wr && in_range(reg_addr, vpic_pkg::ADDR_EN_BASE,
                                          vpic_pkg::N_FLAG_REGS);
    wire logic wr_prio = reg_wr && in_range(reg_addr, vpic_pkg::ADDR_PRIO_BASE,
                                            vpic_pkg::N_PRIO_REGS);
    wire logic wr_sr = reg_wr && reg_addr == vpic_pkg::ADDR_STATUS_WORD;
    wire logic wr_evt = reg_wr && reg_addr == vpic_pkg::ADDR_EVT_STAT;
    wire logic wr_mask = reg_wr && reg_addr == vpic_pkg::ADDR_EVT_MASK;
    wire logic [5:0] flag_off = reg_addr - vpic_pkg::ADDR_FLAG_BASE;
    wire logic [5:0] en_off = reg_addr - vpic_pkg::ADDR_EN_BASE;
    wire logic [5:0] prio_off = reg_addr - vpic_pkg::ADDR_PRIO_BASE;
    wire logic accept = irq_ack && irq_req;

    assign cpu_prio_level = {cpu_prio_high_bit, cpu_prio_low_bits};

    ////////////////////////////////////////////////////////////////////////
    // External edges and request flags
    logic [vpic_pkg::N_EXT-1:0] ext_edge;
    logic [N_SRC-1:0] set_vec;
    logic [FLAG_W-1:0] next_flag;
    logic [FLAG_W-1:0] next_enable;

    always_comb begin
        for (int e = 0; e < vpic_pkg::N_EXT; e++) begin
            ext_edge[e] = ext_edge_polarity[e] ? (ext_prev[e] && !ext_req[e])
                : (!ext_prev[e] && ext_req[e]);
        end
    end

    always_comb begin
        set_vec = periph_req;
        for (int e = 0; e < vpic_pkg::N_EXT; e++) begin
            set_vec[vpic_pkg::EXT_IRQ[e]] = periph_req[vpic_pkg::EXT_IRQ[e]]
                || ext_edge[e];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_comb begin
        next_flag = flag_bits;
        next_enable = enable_bits;
        for (int k = 0; k < vpic_pkg::N_FLAG_REGS; k++) begin
            if (wr_flag && flag_off[2:0] == 3'(k)) begin
                next_flag[16*k +: 16] = reg_wdata;
            end
            if (wr_en && en_off[2:0] == 3'(k)) begin
                next_enable[16*k +: 16] = reg_wdata;
            end
        end
        next_flag = next_flag | {{(FLAG_W-N_SRC){1'b0}}, set_vec};
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration
    logic [3*N_SRC-1:0] prio_flat;
    logic arb_valid;
    logic [6:0] arb_id;
    logic [2:0] arb_prio;
    wire logic [N_SRC-1:0] pend = flag_bits[N_SRC-1:0]
        & enable_bits[N_SRC-1:0];

    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            prio_flat[3*i +: 3] = prio_reg[i / vpic_pkg::PRIO_SLOT]
                [4*(i % vpic_pkg::PRIO_SLOT) +: 3];
        end
    end

    vpic_arbiter #(.N_SRC(N_SRC)) u_arb (
        .pend(pend),
        .prio_flat(prio_flat),
        .level(cpu_prio_level),
        .valid(arb_valid),
        .id(arb_id),
        .prio(arb_prio)
    );

    wire logic next_req = arb_valid && !accept;
    wire logic [7:0] next_vec = {1'b0, arb_id} + vpic_pkg::VEC_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    // Priority level
    logic [2:0] next_low;
    always_comb begin
        next_low = cpu_prio_low_bits;
        if (wr_sr && !nesting_off) begin
            next_low = reg_wdata[vpic_pkg::IPL_LSB +: 3];
        end
        if (accept) begin
            next_low = irq_prio;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events
    wire logic [vpic_pkg::N_EVT-1:0] evt_set = {|trap_flag_set[14:1],
        |ext_edge, next_req && !irq_req};
    wire logic [vpic_pkg::N_EVT-1:0] next_evt =
        (evt_stat & ~(wr_evt ? reg_wdata[vpic_pkg::N_EVT-1:0] : '0)) | evt_set;
    assign irq_out = |(evt_stat & evt_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [15:0] next_rdata;
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_addr == vpic_pkg::ADDR_CTRL_ONE) begin
            next_rdata = irq_global_ctrl_one;
        end else if (reg_addr == vpic_pkg::ADDR_CTRL_TWO) begin
            next_rdata = irq_global_ctrl_two;
        end else if (in_range(reg_addr, vpic_pkg::ADDR_FLAG_BASE,
                              vpic_pkg::N_FLAG_REGS)) begin
            next_rdata = flag_bits[16*flag_off[2:0] +: 16];
        end else if (in_range(reg_addr, vpic_pkg::ADDR_EN_BASE,
                              vpic_pkg::N_FLAG_REGS)) begin
            next_rdata = enable_bits[16*en_off[2:0] +: 16];
        end else if (in_range(reg_addr, vpic_pkg::ADDR_PRIO_BASE,
                              vpic_pkg::N_PRIO_REGS)) begin
            next_rdata = prio_reg[prio_off[4:0]];
        end else if (reg_addr == vpic_pkg::ADDR_STATUS_WORD) begin
            next_rdata[vpic_pkg::IPL_LSB +: 3] = cpu_prio_low_bits;
        end else if (reg_addr == vpic_pkg::ADDR_CORE_CTRL) begin
            next_rdata[vpic_pkg::CPU_PRIO_HIGH_BIT_BIT] = cpu_prio_high_bit;
        end else if (reg_addr == vpic_pkg::ADDR_EVT_STAT) begin
            next_rdata[vpic_pkg::N_EVT-1:0] = evt_stat;
        end else if (reg_addr == vpic_pkg::ADDR_EVT_MASK) begin
            next_rdata[vpic_pkg::N_EVT-1:0] = evt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_global_ctrl_one <= vpic_pkg::CTRL_RST;
            irq_global_ctrl_two <= vpic_pkg::CTRL_RST;
            flag_bits <= '0;
            enable_bits <= '0;
            cpu_prio_low_bits <= vpic_pkg::IPL_RST;
            cpu_prio_high_bit <= 1'b0;
            ext_prev <= '0;
            evt_stat <= '0;
            evt_mask <= '0;
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            // Trap flags stick; software may write them
            irq_global_ctrl_one <= ((wr_one ? reg_wdata : irq_global_ctrl_one)
                & vpic_pkg::CTRL_ONE_WMASK)
                | (trap_flag_set & 16'h7ffe);
            if (wr_two) begin
                irq_global_ctrl_two <= reg_wdata & vpic_pkg::CTRL_TWO_WMASK;
            end
            flag_bits <= next_flag;
            enable_bits <= next_enable;
            cpu_prio_low_bits <= next_low;
            // Only trap entry and exit move the high bit
            if (trap_enter) begin
                cpu_prio_high_bit <= 1'b1;
            end else if (trap_exit) begin
                cpu_prio_high_bit <= 1'b0;
            end
            ext_prev <= ext_req;
            evt_stat <= next_evt;
            if (wr_mask) begin
                evt_mask <= reg_wdata[vpic_pkg::N_EVT-1:0];
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            irq_id <= 7'h00;
            irq_vec_num <= 8'h00;
            irq_vec_addr <= 24'h000000;
            irq_prio <= 3'h0;
        end else if (ce) begin
            irq_req <= next_req;
            irq_id <= arb_id;
            irq_vec_num <= next_vec;
            irq_vec_addr <= vec_addr(alt_table_select, next_vec);
            irq_prio <= arb_prio;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < vpic_pkg::N_PRIO_REGS; r++) begin
                prio_reg[r] <= 16'h0000;
            end
        end else if (ce && wr_prio) begin
            prio_reg[prio_off[4:0]] <= reg_wdata & vpic_pkg::PRIO_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_flag_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && flag_bits[0] && !(reg_wr && reg_addr == vpic_pkg::ADDR_FLAG_BASE)
        |=> flag_bits[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag cleared without a write");

    property p_enable_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        arb_valid |-> enable_bits[arb_id] && flag_bits[arb_id];
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("disabled source selected");

    property p_above_level;
        @(posedge clk_sys) disable iff (!rst_n)
        arb_valid |-> arb_prio > cpu_prio_low_bits
            && prio_flat[3*arb_id +: 3] == arb_prio;
    endproperty
    a_above_level: assert property (p_above_level)
        else $error("winner not above cpu level");

    property p_block_seven;
        @(posedge clk_sys) disable iff (!rst_n)
        cpu_prio_low_bits == 3'h7 |-> !arb_valid;
    endproperty
    a_block_seven: assert property (p_block_seven)
        else $error("request passed at level seven");

    property p_block_high;
        @(posedge clk_sys) disable iff (!rst_n)
        cpu_prio_high_bit |=> !irq_req || !$past(ce);
    endproperty
    a_block_high: assert property (p_block_high)
        else $error("request passed with high level bit");

    property p_vector;
        @(posedge clk_sys) disable iff (!rst_n)
        irq_req |-> irq_vec_num == {1'b0, irq_id} + vpic_pkg::VEC_OFFSET;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector number not request plus eight");

    property p_table;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && arb_valid |=> irq_vec_addr
            == vec_addr($past(alt_table_select), irq_vec_num);
    endproperty
    a_table: assert property (p_table)
        else $error("vector address from wrong table");

    property p_nest_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && nesting_off && wr_sr && !accept
        |=> cpu_prio_low_bits == $past(cpu_prio_low_bits);
    endproperty
    a_nest_lock: assert property (p_nest_lock)
        else $error("level written while nesting off");

    property p_accept;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && accept |=> cpu_prio_low_bits == $past(irq_prio) && !irq_req;
    endproperty
    a_accept: assert property (p_accept)
        else $error("accept did not raise level");

    property p_ext_edge;
        @(posedge clk_sys) disable iff (!rst_n)
        ce && !ext_edge_polarity[1] && !ext_prev[1] && ext_req[1]
        |=> flag_bits[vpic_pkg::EXT_IRQ[1]];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("rising edge did not set flag");

    c_accept: cover property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req ##1 accept);
    c_falling: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ext_edge_polarity[0] && ext_edge[0]);
    c_alt: cover property (@(posedge clk_sys) disable iff (!rst_n)
        irq_req && alt_table_select);
    c_locked: cover property (@(posedge clk_sys) disable iff (!rst_n)
        wr_sr && nesting_off);
endmodule
`default_nettype wire

// file: bench/vpic_core_model.sv
/*
 * Behavioural processor core: accepts a presented request after a set
 * number of wait cycles and keeps what it fetched on acceptance.
 * Assumes the controller's registered request outputs and one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module vpic_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Controller side
    input wire logic irq_req,
    input wire logic [7:0] irq_vec_num,
    input wire logic [23:0] irq_vec_addr,
    input wire logic [2:0] irq_prio,
    output logic irq_ack,
    // Bench control and capture
    input wire logic ack_on,
    input wire logic [1:0] ack_wait,
    output logic [7:0] got_vec,
    output logic [23:0] got_addr,
    output logic [2:0] got_prio,
    output logic [7:0] got_cnt
);
    logic [1:0] wait_cnt;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
            wait_cnt <= 2'h0;
            got_vec <= 8'h00;
            got_addr <= 24'h000000;
            got_prio <= 3'h0;
            got_cnt <= 8'h00;
        end else begin
            irq_ack <= 1'b0;
            if (irq_ack && irq_req) begin
                // Vector fetch on acceptance; handler entry
                got_vec <= irq_vec_num;
                got_addr <= irq_vec_addr;
                got_prio <= irq_prio;
                got_cnt <= got_cnt + 8'h01;
                wait_cnt <= 2'h0;
            end else if (irq_req && ack_on && !irq_ack) begin
                if (wait_cnt == ack_wait) begin
                    irq_ack <= 1'b1;
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/vectored_priority_interrupt_ctrl_test.sv
/*
 * Self-checking bench for the vectored priority interrupt controller.
 * Assumes the core model beside it and the package's register indices.
 */
`timescale 1ns/10ps
`default_nettype none
module vectored_priority_interrupt_ctrl_test;
    logic clk_sys, rst_n, ce, reg_wr, reg_rd, trap_enter, trap_exit;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, trap_flag_set;
    logic [71:0] periph_req;
    logic [4:0] ext_req;
    logic irq_req, irq_ack, irq_out, ack_on;
    logic [7:0] irq_vec_num, got_vec, got_cnt;
    logic [23:0] irq_vec_addr, got_addr;
    logic [2:0] irq_prio, got_prio;
    logic [3:0] cpu_prio_level;
    logic [1:0] ack_wait;
    int miscompares = 0;
    int cmp_count = 0;

    vpic_ctrl #(.N_SRC(72)) DUT (.clk_sys, .rst_n, .ce, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_req, .ext_req,
        .trap_flag_set, .trap_enter, .trap_exit, .irq_req, .irq_vec_num,
        .irq_vec_addr, .irq_prio, .irq_ack, .cpu_prio_level, .irq_out);
    vpic_core_model core (.clk_sys, .rst_n, .irq_req, .irq_vec_num,
        .irq_vec_addr, .irq_prio, .irq_ack, .ack_on, .ack_wait, .got_vec,
        .got_addr, .got_prio, .got_cnt);

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic pulse(input logic [71:0] m);
        @(posedge clk_sys);
        periph_req <= m;
        @(posedge clk_sys);
        periph_req <= '0;
    endtask

    // Read-modify-write of one source's enable bit and priority field
    task automatic set_src(input int n, input logic en, input logic [2:0] p);
        logic [15:0] d;
        logic [5:0] a;
        a = vpic_pkg::ADDR_PRIO_BASE + 6'(n / 4);
        rd(a, d);
        d[(n % 4) * 4 +: 3] = p;
        wr(a, d);
        a = vpic_pkg::ADDR_EN_BASE + 6'(n / 16);
        rd(a, d);
        d[n % 16] = en;
        wr(a, d);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [15:0] d;
        logic [5:0] as [5] = '{vpic_pkg::ADDR_CTRL_ONE,
            vpic_pkg::ADDR_CTRL_TWO, vpic_pkg::ADDR_STATUS_WORD,
            vpic_pkg::ADDR_CORE_CTRL, 6'h3f};
        foreach (as[i]) begin
            rd(as[i], d);
            chk("reset value", 24'(d), 24'h000000);
        end
    endtask

    task automatic t_vector(input int n, input logic [2:0] p,
        input logic alt, input logic [1:0] wt, input logic [23:0] addr);
        logic [15:0] d;
        logic [7:0] c0;
        wr(vpic_pkg::ADDR_CTRL_TWO, {alt, 15'h0000});
        set_src(n, 1'b1, p);
        ack_wait <= wt;
        ack_on <= 1'b1;
        c0 = got_cnt;
        pulse(72'(1) << n);
        for (int i = 0; i < 20 && got_cnt === c0; i++) begin
            idle(1);
        end
        if (got_cnt === c0) begin
            miscompares++;
            wrap_up();
        end
        ack_on <= 1'b0;
        chk("vector number", 24'(got_vec), 24'(n + 8));
        chk("vector address", got_addr, addr);
        chk("accepted priority", 24'(got_prio), 24'(p));
        chk("level raised", 24'(cpu_prio_level), 24'(p));
        chk("request dropped", 24'(irq_req), 24'h0);
        rd(vpic_pkg::ADDR_FLAG_BASE + 6'(n / 16), d);
        chk("flag held", 24'(d[n % 16]), 24'h1);
        d[n % 16] = 1'b0;
        wr(vpic_pkg::ADDR_FLAG_BASE + 6'(n / 16), d);
        set_src(n, 1'b0, 3'h0);
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0000);
    endtask

    task automatic t_block();
        logic [15:0] d;
        set_src(10, 1'b0, 3'h3);
        pulse(72'(1) << 10);
        idle(4);
        chk("disabled source", 24'(irq_req), 24'h0);
        set_src(10, 1'b1, 3'h3);
        idle(3);
        chk("enabled source", 24'(irq_vec_num), 24'd18);
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h00e0);
        idle(3);
        chk("level seven", 24'(cpu_prio_level), 24'h7);
        chk("level seven blocks", 24'(irq_req), 24'h0);
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0000);
        idle(3);
        chk("level zero passes", 24'(irq_req), 24'h1);
        @(posedge clk_sys);
        trap_enter <= 1'b1;
        @(posedge clk_sys);
        trap_enter <= 1'b0;
        idle(3);
        chk("high level bit", 24'(cpu_prio_level), 24'h8);
        chk("high bit blocks", 24'(irq_req), 24'h0);
        wr(vpic_pkg::ADDR_CORE_CTRL, 16'h0000);
        rd(vpic_pkg::ADDR_CORE_CTRL, d);
        chk("core word locked", 24'(d), 24'h000008);
        @(posedge clk_sys);
        trap_exit <= 1'b1;
        @(posedge clk_sys);
        trap_exit <= 1'b0;
        idle(3);
        chk("high bit cleared", 24'(irq_req), 24'h1);
        wr(vpic_pkg::ADDR_FLAG_BASE, 16'h0000);
        set_src(10, 1'b0, 3'h0);
    endtask

    task automatic t_nest();
        logic [15:0] d;
        wr(vpic_pkg::ADDR_CTRL_ONE, 16'h8000);
        @(posedge clk_sys);
        trap_flag_set <= 16'h0002;
        @(posedge clk_sys);
        trap_flag_set <= 16'h0000;
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0060);
        rd(vpic_pkg::ADDR_STATUS_WORD, d);
        chk("level locked", 24'(d), 24'h000000);
        rd(vpic_pkg::ADDR_CTRL_ONE, d);
        chk("control one", 24'(d), 24'h008002);
        wr(vpic_pkg::ADDR_CTRL_ONE, 16'h0000);
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0060);
        ce <= 1'b0;
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0000);
        ce <= 1'b1;
        rd(vpic_pkg::ADDR_STATUS_WORD, d);
        chk("level written", 24'(d), 24'h000060);
        wr(vpic_pkg::ADDR_STATUS_WORD, 16'h0000);
    endtask

    task automatic t_tie();
        set_src(1, 1'b1, 3'h2);
        set_src(2, 1'b1, 3'h6);
        set_src(4, 1'b1, 3'h6);
        pulse(72'h16);
        idle(3);
        chk("tie winner", 24'(irq_vec_num), 24'd10);
        chk("tie priority", 24'(irq_prio), 24'h6);
        set_src(4, 1'b1, 3'h7);
        idle(3);
        chk("higher winner", 24'(irq_vec_num), 24'd12);
        wr(vpic_pkg::ADDR_EN_BASE, 16'h0000);
        wr(vpic_pkg::ADDR_FLAG_BASE, 16'h0000);
    endtask

    task automatic t_ext();
        logic [15:0] d;
        wr(vpic_pkg::ADDR_CTRL_TWO, 16'h0001);
        @(posedge clk_sys);
        ext_req <= 5'h03;
        idle(3);
        rd(vpic_pkg::ADDR_FLAG_BASE, d);
        chk("rise on falling input", 24'(d[0]), 24'h0);
        rd(vpic_pkg::ADDR_FLAG_BASE + 6'h01, d);
        chk("rise on rising input", 24'(d[4]), 24'h1);
        @(posedge clk_sys);
        ext_req <= 5'h00;
        idle(3);
        rd(vpic_pkg::ADDR_FLAG_BASE, d);
        chk("fall on falling input", 24'(d[0]), 24'h1);
        chk("event masked", 24'(irq_out), 24'h0);
        wr(vpic_pkg::ADDR_EVT_MASK, 16'h0002);
        idle(1);
        chk("event raised", 24'(irq_out), 24'h1);
        wr(vpic_pkg::ADDR_EVT_STAT, 16'h0002);
        idle(1);
        chk("event cleared", 24'(irq_out), 24'h0);
        wr(vpic_pkg::ADDR_EVT_MASK, 16'h0000);
        wr(vpic_pkg::ADDR_FLAG_BASE, 16'h0000);
        wr(vpic_pkg::ADDR_FLAG_BASE + 6'h01, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, trap_enter, trap_exit, ack_on} = '0;
        {reg_addr, reg_wdata, trap_flag_set, periph_req, ext_req} = '0;
        ce = 1'b1;
        ack_wait = 2'h0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_vector(3, 3'h5, 1'b0, 2'h0, 24'h00001a);
        t_vector(55, 3'h1, 1'b0, 2'h3, 24'h000082);
        t_vector(55, 3'h7, 1'b1, 2'h0, 24'h000182);
        t_vector(71, 3'h2, 1'b0, 2'h1, 24'h0000a2);
        t_vector(0, 3'h3, 1'b1, 2'h2, 24'h000114);
        t_block();
        t_nest();
        t_tie();
        t_ext();
        wrap_up();
    end
endmodule
`default_nettype wire
